// ---- rtl/bcr_pkg.sv ----
package bcr_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFF_BRIDGE_CTRL = 12'h03C;
   localparam logic [11:0] OFF_IRQ_STATUS  = 12'h100;
   localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h104;
   localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h108;

   // ------------------------------------------------------------
   // Bridge control fields (bit positions in the doubleword)
   // ------------------------------------------------------------
   localparam int BIT_POISON_RESP   = 16;
   localparam int BIT_ERR_FWD_EN    = 17;
   localparam int BIT_IO_ALIAS_EN   = 18;
   localparam int BIT_DISPLAY_EN    = 19;
   localparam int BIT_DISPLAY_WIDE  = 20;
   localparam int BIT_DS_HOT_RESET  = 22;
   localparam logic [31:0] BC_WR_MASK = 32'h005F_0000;
   localparam logic [31:0] BC_RESET   = 32'h0000_0000;

   // ------------------------------------------------------------
   // Legacy decode ranges
   // ------------------------------------------------------------
   localparam logic [31:0] DISP_MEM_LO  = 32'h000A_0000;
   localparam logic [31:0] DISP_MEM_HI  = 32'h000B_FFFF;
   localparam logic [9:0]  DISP_IO_A_LO = 10'h3B0;
   localparam logic [9:0]  DISP_IO_A_HI = 10'h3BB;
   localparam logic [9:0]  DISP_IO_B_LO = 10'h3C0;
   localparam logic [9:0]  DISP_IO_B_HI = 10'h3DF;
   localparam logic [9:0]  ALIAS_BLK_LO = 10'h100;

   // ------------------------------------------------------------
   // Switch topology and interrupt events
   // ------------------------------------------------------------
   localparam int DS_PORTS = 5;
   localparam int EV_W     = 3;
   localparam int EV_POISON = 0;
   localparam int EV_ERRFWD = 1;
   localparam int EV_HOTRST = 2;
   localparam logic [EV_W-1:0] EV_RESET = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/bcr_bridge_ctrl.sv ----
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Poison response bit 16: 0 ignores, 1 reports poisoned secondary TLPs; resets 0.
// - Bit 17 gates forwarding of secondary error messages to primary; resets 0.
// - Alias bit 18 clear: forward every I/O address in window downstream.
// - Alias set: window I/O below 64KB in top 768 bytes per 1KB go upstream; code sends display I/O hits downstream while bit 19 set.
// - Display bit 19 clear: legacy display memory and I/O not forwarded; code still forwards display I/O inside the I/O window downstream while bit 18 clear.
// - Display set: forward memory accesses from 000A0000h through 000BFFFFh.
// - Display set: forward I/O below 64KB with low ten bits 3B0-3BB, 3C0-3DF.
// - Bit 20 picks 10-bit or 16-bit decode for display I/O; resets 0.
// - Bit 22 set triggers hot reset of the port; clear triggers none.
// - Downstream port: assert reset to attached device while bit 22 set.
// - Upstream port: assert reset of every downstream port while bit 22 set.
// - Bits 21 and 23 to 27 are read-only and read zero.
module bcr_bridge_ctrl
   import bcr_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Port role strap, high on the upstream port
   input  wire logic                 is_upstream_port,
   // Secondary-side TLP monitor
   input  wire logic                 sec_tlp_valid,
   input  wire logic                 sec_tlp_poisoned,
   output logic                      poison_report,
   // Secondary error message forwarding
   input  wire logic                 sec_err_valid,
   input  wire logic [1:0]           sec_err_type,
   output logic                      pri_err_valid,
   output logic [1:0]                pri_err_type,
   // Transaction decode
   input  wire logic                 req_valid,
   input  wire logic                 req_is_io,
   input  wire logic [31:0]          req_addr,
   input  wire logic [31:0]          io_window_base,
   input  wire logic [31:0]          io_window_limit,
   output logic                      dec_valid,
   output logic                      dec_fwd_down,
   output logic                      dec_fwd_up,
   // Hot reset
   output logic                      hot_reset_req,
   output logic [DS_PORTS-1:0]       ds_port_rst_n,
   // Interrupt
   output logic                      irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [31:0]          bc_r;
   logic [EV_W-1:0]      irq_status_r;
   logic [EV_W-1:0]      irq_enable_r;
   logic                 irq_r;
   logic                 awready_r;
   logic                 wready_r;
   logic                 aw_held_r;
   logic                 w_held_r;
   logic [ADDR_W-1:0]    awaddr_r;
   logic [31:0]          wdata_r;
   logic [3:0]           wstrb_r;
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 arready_r;
   logic                 rvalid_r;
   logic [31:0]          rdata_r;
   logic [1:0]           rresp_r;
   logic                 up_meta_r;
   logic                 up_sync_r;
   logic                 poison_report_r;
   logic                 pri_err_valid_r;
   logic [1:0]           pri_err_type_r;
   logic                 dec_valid_r;
   logic                 dec_fwd_down_r;
   logic                 dec_fwd_up_r;
   logic                 hot_reset_r;
   logic [DS_PORTS-1:0]  ds_port_rst_n_r;

   logic                 do_write;
   logic [31:0]          byte_mask;
   logic [31:0]          rdata_nxt;
   logic [1:0]           rresp_nxt;
   logic [EV_W-1:0]      ev_set;
   logic [EV_W-1:0]      ev_clr;
   logic                 in_io_window;
   logic                 below_64k;
   logic                 alias_hit;
   logic                 disp_mem_hit;
   logic                 disp_io_hit;
   logic [9:0]           io_low10;

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   // Address and data are taken independently; the write fires once both are held
   assign do_write  = aw_held_r && w_held_r && !bvalid_r;
   assign byte_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

   // Write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end else if (!aw_held_r && !bvalid_r) begin
            awready_r <= 1'b1;
         end
      end
   end

   // Write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b0;
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else begin
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end else if (!w_held_r && !bvalid_r) begin
            wready_r <= 1'b1;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (awaddr_r == OFF_BRIDGE_CTRL || awaddr_r == OFF_IRQ_STATUS ||
                      awaddr_r == OFF_IRQ_ENABLE  || awaddr_r == OFF_IRQ_CLEAR)
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Bridge control register
   // ------------------------------------------------------------
   // Only writable fields are stored, so fixed-zero bits can never leak
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bc_r <= BC_RESET;
      end else if (do_write && awaddr_r == OFF_BRIDGE_CTRL) begin
         bc_r <= (bc_r & ~(byte_mask & BC_WR_MASK)) |
                 (wdata_r & byte_mask & BC_WR_MASK);
      end
   end

   // Interrupt enable register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable_r <= EV_RESET;
      end else if (do_write && awaddr_r == OFF_IRQ_ENABLE && wstrb_r[0]) begin
         irq_enable_r <= wdata_r[EV_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   // Clear register is write-only and reads as zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
         OFF_BRIDGE_CTRL: rdata_nxt = bc_r & BC_WR_MASK;
         OFF_IRQ_STATUS:  rdata_nxt = {29'h0000_0000, irq_status_r};
         OFF_IRQ_ENABLE:  rdata_nxt = {29'h0000_0000, irq_enable_r};
         OFF_IRQ_CLEAR:   rdata_nxt = 32'h0000_0000;
         default:         rresp_nxt = RESP_SLVERR;
      endcase
   end

   // One read in flight; data latched at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end else if (!rvalid_r) begin
            arready_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Port role strap synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_meta_r <= 1'b0;
         up_sync_r <= 1'b0;
      end else begin
         up_meta_r <= is_upstream_port;
         up_sync_r <= up_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Poisoned TLP reporting and error forwarding
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         poison_report_r <= 1'b0;
      end else begin
         poison_report_r <= sec_tlp_valid && sec_tlp_poisoned && bc_r[BIT_POISON_RESP];
      end
   end

   a_poison_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      (sec_tlp_valid && sec_tlp_poisoned) |=> (poison_report_r == $past(bc_r[BIT_POISON_RESP])))
      else $error("poison report does not follow enable");

   // Type travels with the valid so the primary side sees a matched pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pri_err_valid_r <= 1'b0;
         pri_err_type_r  <= 2'h0;
      end else begin
         pri_err_valid_r <= sec_err_valid && bc_r[BIT_ERR_FWD_EN];
         if (sec_err_valid) begin
            pri_err_type_r <= sec_err_type;
         end
      end
   end

   a_err_forward: assert property (@(posedge aclk) disable iff (!aresetn)
      sec_err_valid |=> (pri_err_valid_r == $past(bc_r[BIT_ERR_FWD_EN])) &&
                        (pri_err_type_r == $past(sec_err_type)))
      else $error("error message forwarding mismatch");

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   assign io_low10     = req_addr[9:0];
   assign below_64k    = (req_addr[31:16] == 16'h0000);
   assign in_io_window = (req_addr >= io_window_base) && (req_addr <= io_window_limit);
   // Top 768 bytes of each 1KB block: offset 100h and above
   assign alias_hit    = below_64k && (io_low10 >= ALIAS_BLK_LO);
   assign disp_mem_hit = (req_addr >= DISP_MEM_LO) && (req_addr <= DISP_MEM_HI);
   // 10-bit decode lets aliases above 3FFh through; wide decode demands 15:10 zero
   assign disp_io_hit  = below_64k &&
                         (!bc_r[BIT_DISPLAY_WIDE] || req_addr[15:10] == 6'h00) &&
                         ((io_low10 >= DISP_IO_A_LO && io_low10 <= DISP_IO_A_HI) ||
                          (io_low10 >= DISP_IO_B_LO && io_low10 <= DISP_IO_B_HI));

   // Display ranges take priority over the I/O window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_valid_r    <= 1'b0;
         dec_fwd_down_r <= 1'b0;
         dec_fwd_up_r   <= 1'b0;
      end else begin
         dec_valid_r    <= req_valid;
         dec_fwd_down_r <= 1'b0;
         dec_fwd_up_r   <= 1'b0;
         if (req_valid) begin
            if (bc_r[BIT_DISPLAY_EN] && (req_is_io ? disp_io_hit : disp_mem_hit)) begin
               dec_fwd_down_r <= 1'b1;
            end else if (req_is_io && in_io_window) begin
               if (bc_r[BIT_IO_ALIAS_EN] && alias_hit) begin
                  dec_fwd_up_r <= 1'b1;
               end else begin
                  dec_fwd_down_r <= 1'b1;
               end
            end
         end
      end
   end

   a_window_down: assert property (@(posedge aclk) disable iff (!aresetn)
      (req_valid && req_is_io && in_io_window && !bc_r[BIT_IO_ALIAS_EN]) |=> dec_fwd_down_r)
      else $error("window I/O not forwarded downstream");

   a_alias_up: assert property (@(posedge aclk) disable iff (!aresetn)
      dec_fwd_up_r |-> $past(bc_r[BIT_IO_ALIAS_EN]) && $past(req_is_io) &&
                       ($past(req_addr[9:8]) != 2'h0) && ($past(req_addr[31:16]) == 16'h0000))
      else $error("upstream alias outside legal range");

   a_display_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (req_valid && !req_is_io && !bc_r[BIT_DISPLAY_EN]) |=> !dec_fwd_down_r)
      else $error("display memory forwarded while disabled");

   a_display_mem: assert property (@(posedge aclk) disable iff (!aresetn)
      (req_valid && !req_is_io && bc_r[BIT_DISPLAY_EN] &&
       req_addr >= 32'h000A_0000 && req_addr <= 32'h000B_FFFF) |=> dec_fwd_down_r)
      else $error("display memory not forwarded");

   a_display_wide: assert property (@(posedge aclk) disable iff (!aresetn)
      (req_valid && req_is_io && bc_r[BIT_DISPLAY_EN] && bc_r[BIT_DISPLAY_WIDE] &&
       req_addr[15:10] != 6'h00 && !in_io_window) |=> !dec_fwd_down_r)
      else $error("wide decode forwarded an alias");

   // ------------------------------------------------------------
   // Hot reset
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hot_reset_r <= 1'b0;
      end else begin
         hot_reset_r <= bc_r[BIT_DS_HOT_RESET];
      end
   end

   // Port 0 is this port's own link; upstream role fans out to all
   generate
      for (genvar gi = 0; gi < DS_PORTS; gi++) begin : g_port_rst
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ds_port_rst_n_r[gi] <= 1'b1;
            end else begin
               ds_port_rst_n_r[gi] <= !(bc_r[BIT_DS_HOT_RESET] &&
                                        (up_sync_r || gi == 0));
            end
         end
      end
   endgenerate

   a_hot_none: assert property (@(posedge aclk) disable iff (!aresetn)
      !bc_r[BIT_DS_HOT_RESET] |=> (&ds_port_rst_n_r) && !hot_reset_r)
      else $error("reset asserted while hot reset clear");

   a_ds_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      bc_r[BIT_DS_HOT_RESET] |=> !ds_port_rst_n_r[0] && hot_reset_r)
      else $error("own port reset missing");

   a_up_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      (bc_r[BIT_DS_HOT_RESET] && up_sync_r) |=> (ds_port_rst_n_r == '0))
      else $error("upstream hot reset did not reach all ports");

   a_fixed_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && $past(s_axi_araddr) == OFF_BRIDGE_CTRL && $past(s_axi_arvalid) &&
       $past(s_axi_arready)) |-> (s_axi_rdata[31:23] == 9'h000 && !s_axi_rdata[21]))
      else $error("fixed-zero bits read nonzero");

   // ------------------------------------------------------------
   // Interrupt status, clear and output
   // ------------------------------------------------------------
   assign ev_set[EV_POISON] = poison_report_r;
   assign ev_set[EV_ERRFWD] = pri_err_valid_r;
   assign ev_set[EV_HOTRST] = hot_reset_r ^ bc_r[BIT_DS_HOT_RESET] ? bc_r[BIT_DS_HOT_RESET] : 1'b0;
   assign ev_clr = (do_write && awaddr_r == OFF_IRQ_CLEAR && wstrb_r[0]) ?
                   wdata_r[EV_W-1:0] : EV_RESET;

   // Set beats clear so a same-cycle event is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_r <= EV_RESET;
      end else begin
         irq_status_r <= (irq_status_r & ~ev_clr) | ev_set;
      end
   end

   // Level output from a flop, so enable and status updates cannot glitch it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_enable_r);
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign poison_report = poison_report_r;
   assign pri_err_valid = pri_err_valid_r;
   assign pri_err_type  = pri_err_type_r;
   assign dec_valid     = dec_valid_r;
   assign dec_fwd_down  = dec_fwd_down_r;
   assign dec_fwd_up    = dec_fwd_up_r;
   assign hot_reset_req = hot_reset_r;
   assign ds_port_rst_n = ds_port_rst_n_r;
   assign irq           = irq_r;

endmodule // bcr_bridge_ctrl

// ---- verification/bridge_control_register_test.sv ----
`timescale 1ns/1ps
module bridge_control_register_test
   import bcr_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ups, smp;
   logic        tv, tp, ev, rv, rio, awready, wready, bvalid, arready, rvalid, stim_v;
   logic        prep, pev, dv, dd, du, hrq, irq;
   logic        stim_d = 1'b0;
   logic [1:0]  et, bresp, rresp, pet;
   logic [2:0]  st;
   logic [3:0]  wstrb;
   logic [4:0]  dsr;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, ra, wb, wl, rdata, x, bc;
   logic [33:0] r_q[$];
   logic [1:0]  b_q[$];
   logic [6:0]  s_q[$];
   logic [6:0]  l_q[$];
   int          num_errors, n_compared;

   always #5 aclk = ~aclk;

   bcr_bridge_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .is_upstream_port(ups), .sec_tlp_valid(tv), .sec_tlp_poisoned(tp),
      .poison_report(prep), .sec_err_valid(ev), .sec_err_type(et), .pri_err_valid(pev),
      .pri_err_type(pet), .req_valid(rv), .req_is_io(rio), .req_addr(ra),
      .io_window_base(wb), .io_window_limit(wl), .dec_valid(dv), .dec_fwd_down(dd),
      .dec_fwd_up(du), .hot_reset_req(hrq), .ds_port_rst_n(dsr), .irq(irq));

   // ----------------------------------------
   // Comparison, verdict, stimulus helpers
   // ----------------------------------------
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] e);
      b_q.push_back(e);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      r_q.push_back(e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask

   // Settle time covers the two-flop strap sync plus the output flop
   task automatic lvl(input logic [6:0] e);
      repeat (4) @(posedge aclk);
      l_q.push_back(e);
      smp <= 1'b1;
      @(posedge aclk);
      smp <= 1'b0;
   endtask

   // Random traffic on monitor and decode inputs, one item per cycle
   task automatic stream(input int n);
      logic [31:0] a;
      logic [9:0]  lo;
      logic        hit, win, up;
      repeat (n) begin
         @(posedge aclk);
         x = xs(x);
         case (x[1:0])
            2'h0: a = 32'h0009_FFF0 + {14'h0, x[21:4]};
            2'h1: a = {16'h0, x[15:10] & {6{x[22]}}, 10'h3A0 + {4'h0, x[9:4]}};
            2'h2: a = {15'h0, x[20:4]};
            default: a = x;
         endcase
         lo = a[9:0];
         hit = bc[19] && (x[23] ? (a[31:16] == 16'h0 && (!bc[20] || a[15:10] == 6'h0)
               && ((lo >= 10'h3B0 && lo <= 10'h3BB) || (lo >= 10'h3C0 && lo <= 10'h3DF)))
               : (a >= 32'h000A_0000 && a <= 32'h000B_FFFF));
         win = x[23] && a >= wb && a <= wl;
         up = !hit && win && bc[18] && a < 32'h0001_0000 && lo >= 10'h100;
         {tv, tp, ev, et, rv, rio} <= x[29:23];
         ra <= a;
         stim_v <= 1'b1;
         s_q.push_back({x[29] && x[28] && bc[16], x[27] && bc[17], x[27] && bc[17] ?
            x[26:25] : 2'h0, x[24], x[24] && (hit || (win && !up)), x[24] && up});
         st = st | {1'b0, x[27] && bc[17], x[29] && x[28] && bc[16]};
      end
      @(posedge aclk);
      {tv, ev, rv, stim_v} <= '0;
   endtask

   // Oldest note is taken whenever a result shows at the outputs
   always @(posedge aclk) begin
      stim_d <= stim_v;
      if (bvalid && bready) check(34'(bresp), 34'(b_q.pop_front()));
      if (rvalid && rready) check({rresp, rdata}, r_q.pop_front());
      if (stim_d) check(34'({prep, pev, pev ? pet : 2'h0, dv, dv && dd, dv && du}),
         34'(s_q.pop_front()));
      if (smp) check(34'({irq, hrq, dsr}), 34'(l_q.pop_front()));
   end

   // Whole run is about 1600 cycles; this leaves ample margin
   initial begin
      #400000;
      num_errors++;
      $display("watchdog expired");
      conclude();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ups, smp} = '0;
      {tv, tp, ev, et, rv, rio, stim_v, awaddr, araddr, wdata, wstrb, ra, bc} = '0;
      wb = 32'h0000_0300;
      wl = 32'h0001_03FF;
      x = 32'h0000_B1C3;
      num_errors = 0;
      n_compared = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_BRIDGE_CTRL, {RESP_OKAY, 32'h0});
      rd(12'h200, {RESP_SLVERR, 32'h0});
      wr(12'h200, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      wr(OFF_BRIDGE_CTRL, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(OFF_BRIDGE_CTRL, {RESP_OKAY, 32'h005F_0000});
      wr(OFF_BRIDGE_CTRL, 32'h0, 4'h3, RESP_OKAY);
      rd(OFF_BRIDGE_CTRL, {RESP_OKAY, 32'h005F_0000});
      wr(OFF_BRIDGE_CTRL, 32'h0, 4'hF, RESP_OKAY);
      wr(OFF_IRQ_ENABLE, 32'h7, 4'hF, RESP_OKAY);
      lvl({1'b1, 1'b0, 5'h1F});
      wr(OFF_IRQ_CLEAR, 32'h7, 4'h1, RESP_OKAY);
      st = 3'h0;
      $display("test registers done");
      for (int m = 0; m < 32; m++) begin
         bc = {11'h0, m[4:0], 16'h0};
         wr(OFF_BRIDGE_CTRL, bc, 4'hF, RESP_OKAY);
         stream(40);
      end
      rd(OFF_IRQ_STATUS, {RESP_OKAY, 29'h0, st});
      lvl({|st, 1'b0, 5'h1F});
      wr(OFF_IRQ_CLEAR, 32'h7, 4'h1, RESP_OKAY);
      rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0});
      lvl({1'b0, 1'b0, 5'h1F});
      $display("test stream done");
      wr(OFF_BRIDGE_CTRL, 32'h0040_0000, 4'h4, RESP_OKAY);
      lvl({1'b1, 1'b1, 5'h1E});
      ups <= 1'b1;
      lvl({1'b1, 1'b1, 5'h00});
      wr(OFF_IRQ_ENABLE, 32'h0, 4'hF, RESP_OKAY);
      wr(OFF_BRIDGE_CTRL, 32'h0, 4'hF, RESP_OKAY);
      lvl({1'b0, 1'b0, 5'h1F});
      rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h4});
      $display("test hot reset done");
      // Mid-run reset with every field set; all must come back cleared
      wr(OFF_BRIDGE_CTRL, 32'h005F_0000, 4'hF, RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_BRIDGE_CTRL, {RESP_OKAY, 32'h0});
      rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0});
      lvl({1'b0, 1'b0, 5'h1F});
      $display("test mid reset done");
      conclude();
   end
endmodule // bridge_control_register_test
